// ===== hw/gpc_map.svh
// Constants for the general purpose pin block
// What this block does
// - Seven pins, each set on its own to input or output; pins 0, 2, 7, 8 and 9 can also be set to an alternate function.
// - Each pin owns the same bit position in the select, direction and data vectors.
// - Select 1 gives the alternate function, else direction 0 is input and 1 is output.
// - Pins 0, 8 and 9 carry the low-active reset outputs of downstream ports 2, 1 and 3.
// - Pin 2 carries the low-active expander interrupt input, pin 7 the low-active event output.
// - After reset every pin is a plain input with select and direction cleared.
// - Pin levels are sampled no more than once per 128 ns, with asynchronous inputs allowed.
// - An alternate function not in use is held inactive.
// - An input pin's sampled level is registered into its data bit.
// - Reading the data vector returns sampled pin levels in every mode.
// - An output pin drives the value held in its data bit.
// - The three vectors are reached only through upstream port configuration space.
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
`define GPC_VEC_W 10
`define GPC_PIN_MASK 10'h38f
`define GPC_ALT_OUT_MASK 10'h381
`define GPC_CFG_RESET 10'h000
`define GPC_PIN_PORT2_RST 0
`define GPC_PIN_EXP_IRQ 2
`define GPC_PIN_EVENT 7
`define GPC_PIN_PORT1_RST 8
`define GPC_PIN_PORT3_RST 9
`define GPC_SAMPLE_PERIOD_NS 128
`define GPC_CLK_PERIOD_NS 8
`define GPC_SAMPLE_CYC ((`GPC_SAMPLE_PERIOD_NS + `GPC_CLK_PERIOD_NS - 1) / `GPC_CLK_PERIOD_NS)
`endif

// ===== hw/gpc_pkg.sv
// Types shared by the general purpose pin block
`default_nettype none
`include "gpc_map.svh"
package gpc_pkg;
  typedef logic [`GPC_VEC_W-1:0] gpc_vec_t;

  typedef struct packed {
    logic wr_func;
    logic wr_dir;
    logic wr_data;
    gpc_vec_t wdata;
  } gpc_cfg_s;

  typedef struct packed {
    gpc_vec_t func;
    gpc_vec_t dir;
    gpc_vec_t data;
  } gpc_rd_s;

  typedef struct packed {
    logic port1_reset_n;
    logic port2_reset_n;
    logic port3_reset_n;
    logic event_n;
  } gpc_alt_s;

  typedef struct packed {
    gpc_vec_t sync1;
    gpc_vec_t sync2;
    gpc_vec_t samp;
    logic [7:0] cnt;
    logic en;
  } gpc_smp_s;

  typedef struct packed {
    gpc_vec_t func;
    gpc_vec_t dir;
    gpc_vec_t dout;
  } gpc_st_s;

  function automatic gpc_vec_t gpc_mask(input gpc_vec_t v);
    gpc_mask = v & `GPC_PIN_MASK;
  endfunction : gpc_mask
endpackage : gpc_pkg
`default_nettype wire

// ===== hw/gpc_pin_sampler.sv
// Pin synchroniser and slow sampler
`timescale 1ns/1ps
`default_nettype none
`include "gpc_map.svh"
module gpc_pin_sampler import gpc_pkg::*; #(
  parameter int SAMPLE_CYC = `GPC_SAMPLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire gpc_vec_t pin_in,
  output gpc_vec_t pin_sync,
  output gpc_vec_t pin_sampled,
  output logic sample_en
);
  gpc_smp_s st_reg;
  gpc_smp_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = pin_in;
    st_next.sync2 = st_reg.sync1;
    st_next.en = 1'b0;
    if (st_reg.cnt == 8'(SAMPLE_CYC - 1)) begin
      st_next.cnt = 8'h00;
      st_next.en = 1'b1;
      st_next.samp = gpc_mask(st_reg.sync2);
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_sync = gpc_mask(st_reg.sync2);
  assign pin_sampled = st_reg.samp;
  assign sample_en = st_reg.en;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_sample_gap;
    sample_en |=> (!sample_en) [*8] ##1 (!sample_en) [*7];
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("samples too close");
endmodule : gpc_pin_sampler
`default_nettype wire

// ===== hw/gpc_pin_control.sv
// General purpose pin control block
`timescale 1ns/1ps
`default_nettype none
`include "gpc_map.svh"
module gpc_pin_control import gpc_pkg::*; #(
  parameter int SAMPLE_CYC = `GPC_SAMPLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire gpc_cfg_s cfg_req,
  output gpc_rd_s cfg_rd,
  input wire gpc_vec_t pin_in,
  output gpc_vec_t pin_out,
  output gpc_vec_t pin_oe,
  input wire gpc_alt_s alt_src,
  output logic expander_irq0_in_n
);
  gpc_st_s st_reg;
  gpc_st_s st_next;
  gpc_vec_t pin_sync;
  gpc_vec_t pin_sampled;
  logic sample_en;
  gpc_vec_t alt_val;

  gpc_pin_sampler #(.SAMPLE_CYC(SAMPLE_CYC)) u_smp (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(pin_in),
    .pin_sync(pin_sync),
    .pin_sampled(pin_sampled),
    .sample_en(sample_en)
  );

  always_comb begin
    st_next = st_reg;
    if (cfg_req.wr_func) begin
      st_next.func = gpc_mask(cfg_req.wdata);
    end
    if (cfg_req.wr_dir) begin
      st_next.dir = gpc_mask(cfg_req.wdata);
    end
    if (cfg_req.wr_data) begin
      st_next.dout = gpc_mask(cfg_req.wdata);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{func: `GPC_CFG_RESET, dir: `GPC_CFG_RESET, dout: `GPC_CFG_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    alt_val = '1;
    alt_val[`GPC_PIN_PORT2_RST] = alt_src.port2_reset_n;
    alt_val[`GPC_PIN_PORT1_RST] = alt_src.port1_reset_n;
    alt_val[`GPC_PIN_PORT3_RST] = alt_src.port3_reset_n;
    alt_val[`GPC_PIN_EVENT] = alt_src.event_n;
  end

  localparam gpc_vec_t PIN_MASK = `GPC_PIN_MASK;
  localparam gpc_vec_t ALT_OUT = `GPC_ALT_OUT_MASK;

  genvar i;
  generate
    for (i = 0; i < `GPC_VEC_W; i++) begin : g_pin
      assign pin_oe[i] = PIN_MASK[i] & (st_reg.func[i] ? ALT_OUT[i] : st_reg.dir[i]);
      assign pin_out[i] = PIN_MASK[i] & (st_reg.func[i] ? alt_val[i] : st_reg.dout[i]);
    end
  endgenerate

  assign expander_irq0_in_n = st_reg.func[`GPC_PIN_EXP_IRQ] ? pin_sync[`GPC_PIN_EXP_IRQ] : 1'b1;

  assign cfg_rd = '{func: st_reg.func, dir: st_reg.dir, data: pin_sampled};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_out_drive;
    (!st_reg.func[1] && st_reg.dir[1]) |-> (pin_oe[1] && pin_out[1] == st_reg.dout[1]);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output pin not driven");

  property p_input_float;
    (!st_reg.func[3] && !st_reg.dir[3]) |-> !pin_oe[3];
  endproperty
  a_input_float: assert property (p_input_float) else $error("input pin driven");

  property p_alt_reset;
    st_reg.func[`GPC_PIN_PORT1_RST] |->
      (pin_oe[`GPC_PIN_PORT1_RST] && pin_out[`GPC_PIN_PORT1_RST] == alt_src.port1_reset_n);
  endproperty
  a_alt_reset: assert property (p_alt_reset) else $error("port1 reset not routed");

  property p_alt_event;
    st_reg.func[`GPC_PIN_EVENT] |-> (pin_out[`GPC_PIN_EVENT] == alt_src.event_n);
  endproperty
  a_alt_event: assert property (p_alt_event) else $error("event not routed");

  property p_irq_idle;
    !st_reg.func[`GPC_PIN_EXP_IRQ] |-> expander_irq0_in_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("unused irq active");

  property p_reset_input;
    $past(rst) |-> (st_reg.func == '0 && st_reg.dir == '0);
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("not input after reset");

  property p_data_hold;
    $changed(cfg_rd.data) |-> sample_en;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data changed off sample");

  sequence s_pin_step;
    ##2 sample_en;
  endsequence
  property p_read_level;
    (pin_in == '0) [*3] ##0 s_pin_step |=> cfg_rd.data == '0;
  endproperty
  a_read_level: assert property (p_read_level) else $error("readback not pin level");

  property p_unused_bits;
    ((st_reg.func | st_reg.dir | pin_oe) & ~PIN_MASK) == '0;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused pin active");

  property p_cfg_write;
    cfg_req.wr_dir |=> st_reg.dir == gpc_mask($past(cfg_req.wdata));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("direction write lost");

  property p_func_write;
    cfg_req.wr_func |=> st_reg.func == gpc_mask($past(cfg_req.wdata));
  endproperty
  a_func_write: assert property (p_func_write) else $error("select write lost");

  property p_data_write;
    cfg_req.wr_data |=> st_reg.dout == gpc_mask($past(cfg_req.wdata));
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write lost");

  property p_func_hold;
    !cfg_req.wr_func |=> $stable(st_reg.func);
  endproperty
  a_func_hold: assert property (p_func_hold) else $error("select changed unasked");

  property p_dir_hold;
    !cfg_req.wr_dir |=> $stable(st_reg.dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed unasked");

  property p_alt_port2;
    st_reg.func[`GPC_PIN_PORT2_RST] |->
      (pin_oe[`GPC_PIN_PORT2_RST] && pin_out[`GPC_PIN_PORT2_RST] == alt_src.port2_reset_n);
  endproperty
  a_alt_port2: assert property (p_alt_port2) else $error("port2 reset not routed");

  property p_alt_port3;
    st_reg.func[`GPC_PIN_PORT3_RST] |->
      (pin_oe[`GPC_PIN_PORT3_RST] && pin_out[`GPC_PIN_PORT3_RST] == alt_src.port3_reset_n);
  endproperty
  a_alt_port3: assert property (p_alt_port3) else $error("port3 reset not routed");

  property p_event_drive;
    st_reg.func[`GPC_PIN_EVENT] |-> pin_oe[`GPC_PIN_EVENT];
  endproperty
  a_event_drive: assert property (p_event_drive) else $error("event pin not driven");

  property p_irq_float;
    st_reg.func[`GPC_PIN_EXP_IRQ] |-> !pin_oe[`GPC_PIN_EXP_IRQ];
  endproperty
  a_irq_float: assert property (p_irq_float) else $error("irq input pin driven");

  property p_irq_follow;
    (st_reg.func[`GPC_PIN_EXP_IRQ] && $past(st_reg.func[`GPC_PIN_EXP_IRQ], 2)) |->
      expander_irq0_in_n == $past(pin_in[`GPC_PIN_EXP_IRQ], 2);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not synchronised pin");

  property p_sample_store;
    sample_en |-> cfg_rd.data == gpc_mask($past(pin_in, 3));
  endproperty
  a_sample_store: assert property (p_sample_store) else $error("sample not pin level");

  property p_reset_pins;
    $past(rst) |-> (pin_oe == '0 && pin_out == '0 && expander_irq0_in_n);
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins active after reset");

  property p_unimpl_out;
    (pin_out & ~PIN_MASK) == '0;
  endproperty
  a_unimpl_out: assert property (p_unimpl_out) else $error("unused pin output set");

  property p_no_alt_drive;
    (st_reg.func & ~ALT_OUT & pin_oe) == '0;
  endproperty
  a_no_alt_drive: assert property (p_no_alt_drive) else $error("alternate input driven");

  generate
    for (i = 0; i < `GPC_VEC_W; i++) begin : g_pin_chk
      if (PIN_MASK[i]) begin : g_impl
        property p_pin_out;
          (!st_reg.func[i] && st_reg.dir[i]) |->
            (pin_oe[i] && pin_out[i] == st_reg.dout[i]);
        endproperty
        a_pin_out: assert property (p_pin_out) else $error("output pin mismatch");

        property p_pin_in;
          (!st_reg.func[i] && !st_reg.dir[i]) |-> !pin_oe[i];
        endproperty
        a_pin_in: assert property (p_pin_in) else $error("input pin driven");
      end
    end
  endgenerate
endmodule : gpc_pin_control
`default_nettype wire

// ===== verification/gpc_board_model.sv
// Board parts that drive the pins the block leaves released
`timescale 1ns/1ps
`default_nettype none
module gpc_board_model import gpc_pkg::*; (
  input wire gpc_vec_t pin_out,
  input wire gpc_vec_t pin_oe,
  input wire gpc_vec_t board_level,
  output gpc_vec_t pin_level
);
  assign pin_level = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule : gpc_board_model
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module testbench import gpc_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  gpc_cfg_s cfg_req = '0;
  gpc_alt_s alt_src = 4'hf;
  gpc_vec_t board = 10'h000;
  gpc_rd_s cfg_rd;
  gpc_vec_t pin_in;
  gpc_vec_t pin_out;
  gpc_vec_t pin_oe;
  logic irq_n;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  always #4 core_clk = ~core_clk;
  gpc_pin_control #(.SAMPLE_CYC(16)) uut (.core_clk(core_clk), .rst(rst), .cfg_req(cfg_req),
    .cfg_rd(cfg_rd), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_src(alt_src),
    .expander_irq0_in_n(irq_n));
  gpc_board_model board_m (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board),
    .pin_level(pin_in));
  task automatic chk(input string name, input gpc_vec_t seen, input gpc_vec_t exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Kind 0 select, 1 direction, 2 data
  task automatic wr(input int kind, input gpc_vec_t v);
    @(negedge core_clk);
    cfg_req.wdata = v;
    cfg_req.wr_func = (kind == 0);
    cfg_req.wr_dir = (kind == 1);
    cfg_req.wr_data = (kind == 2);
    @(negedge core_clk);
    cfg_req = '0;
  endtask : wr
  // Longer than the worst sampling delay
  task automatic settle;
    repeat (20) @(negedge core_clk);
  endtask : settle
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_reset;
    chk("func", cfg_rd.func, 10'h000);
    chk("dir", cfg_rd.dir, 10'h000);
    chk("oe", pin_oe, 10'h000);
    chk("out", pin_out, 10'h000);
    chk("irq", {9'h000, irq_n}, 10'h001);
  endtask : t_reset
  task automatic t_output;
    wr(1, 10'h3ff);
    chk("dir", cfg_rd.dir, 10'h38f);
    wr(2, 10'h285);
    board = 10'h17a;
    chk("oe", pin_oe, 10'h38f);
    chk("out", pin_out & 10'h38f, 10'h285);
    settle();
    chk("data", cfg_rd.data, 10'h285);
  endtask : t_output
  task automatic t_input;
    wr(1, 10'h000);
    board = 10'h30a;
    @(negedge core_clk);
    chk("early", cfg_rd.data, 10'h285);
    chk("oe", pin_oe, 10'h000);
    settle();
    chk("data", cfg_rd.data, 10'h30a);
  endtask : t_input
  task automatic t_alt;
    wr(1, 10'h3ff);
    board = 10'h000;
    alt_src = 4'b0101;
    wr(0, 10'h385);
    chk("func", cfg_rd.func, 10'h385);
    chk("oe", pin_oe, 10'h38b);
    chk("out", pin_out & 10'h381, 10'h081);
    alt_src = 4'b1010;
    @(negedge core_clk);
    chk("out", pin_out & 10'h381, 10'h300);
    alt_src = 4'b0101;
    settle();
    chk("irq", {9'h000, irq_n}, 10'h000);
    board = 10'h004;
    settle();
    chk("irq", {9'h000, irq_n}, 10'h001);
    chk("data", cfg_rd.data, 10'h085);
    board = 10'h000;
    wr(0, 10'h000);
    settle();
    chk("irq", {9'h000, irq_n}, 10'h001);
    chk("out", pin_out & 10'h381, 10'h281);
  endtask : t_alt
  // Reset again in mid-run while pins are configured
  task automatic t_rereset;
    wr(1, 10'h3ff);
    wr(0, 10'h385);
    @(negedge core_clk);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk("func", cfg_rd.func, 10'h000);
    chk("dir", cfg_rd.dir, 10'h000);
    chk("oe", pin_oe, 10'h000);
    chk("out", pin_out, 10'h000);
    chk("data", cfg_rd.data, 10'h000);
    chk("irq", {9'h000, irq_n}, 10'h001);
    wr(1, 10'h002);
    chk("dir", cfg_rd.dir, 10'h002);
    chk("oe", pin_oe, 10'h002);
  endtask : t_rereset
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_output();
    t_input();
    t_alt();
    t_rereset();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
